// *** rtl/cmdsel_pkg.sv ***
package cmdsel_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_START = 8'h00;
    localparam logic [7:0] OFS_SPEED = 8'h04;
    localparam logic [7:0] OFS_NET = 8'h08;
    localparam logic [7:0] OFS_PU = 8'h0C;
    localparam logic [7:0] OFS_USERGRP = 8'h10;
    localparam logic [7:0] OFS_MODESEL = 8'h14;
    localparam logic [7:0] OFS_MODEREQ = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // setting encodings
    localparam logic [15:0] SRC_COMM = 16'h0000;
    localparam logic [15:0] SRC_EXT = 16'h0001;
    localparam logic [15:0] SPEED_EXT_COMM = 16'h0002;
    localparam logic [15:0] NET_OPTION = 16'h0000;
    localparam logic [15:0] NET_RS485 = 16'h0001;
    localparam logic [15:0] NET_AUTO = 16'h270F;
    localparam logic [15:0] PU_RS485 = 16'h0001;
    localparam logic [15:0] PU_CONNECTOR = 16'h0002;
    localparam logic [15:0] USERGRP_OPEN = 16'h0000;
    localparam logic [15:0] MODESEL_MAX = 16'h0007;

    // reset values of the settings
    localparam logic [15:0] START_RST = SRC_COMM;
    localparam logic [15:0] SPEED_RST = SRC_COMM;
    localparam logic [15:0] NET_RST = NET_AUTO;
    localparam logic [15:0] PU_RST = PU_CONNECTOR;
    localparam logic [15:0] USERGRP_RST = 16'h0000;
    localparam logic [15:0] MODESEL_RST = 16'h0000;

    // status register field positions
    localparam int ST_MODE_LSB = 0;
    localparam int ST_ROUTE_LSB = 4;
    localparam int ST_REFUSED = 14;
    localparam int ST_OPTION = 15;

    // operation mode, one-hot
    typedef enum logic [3:0] {
        MODE_EXT = 4'b0001,
        MODE_PU = 4'b0010,
        MODE_NET = 4'b0100,
        MODE_COMB = 4'b1000
    } mode_t;

    // command routing presented to the drive
    typedef struct packed {
        logic startComm;
        logic startExt;
        logic freqComm;
        logic freqExt;
        logic term2Ignore;
        logic rs485Cmd;
        logic optionCmd;
        logic connectorCmd;
        logic rs485Blocked;
        logic netLocked;
    } route_t;

    // state of the option pin synchroniser
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
    } sync_t;

    // state of the selector
    typedef struct packed {
        logic booted;
        mode_t opMode;
        logic refused;
        logic [15:0] startSrc;
        logic [15:0] speedSrc;
        logic [15:0] netSrc;
        logic [15:0] puSrc;
        logic [15:0] userGroup;
        logic [15:0] modeSel;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        route_t route;
    } state_t;

    localparam state_t STATE_RST = '{
        booted: 1'b0,
        opMode: MODE_EXT,
        refused: 1'b0,
        startSrc: START_RST,
        speedSrc: SPEED_RST,
        netSrc: NET_RST,
        puSrc: PU_RST,
        userGroup: USERGRP_RST,
        modeSel: MODESEL_RST,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000,
        route: '0
    };

endpackage

// *** rtl/option_sync.sv ***
`timescale 1ns/1ps
module option_sync (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // asynchronous pin and its clean level
    input wire logic pinIn,
    output logic level
);

    cmdsel_pkg::sync_t state;
    cmdsel_pkg::sync_t next_state;

    // three-stage chain; the level follows once stages two and three agree
    always_comb
    begin
        next_state = state;
        next_state.ff1 = pinIn;
        next_state.ff2 = state.ff1;
        next_state.ff3 = state.ff2;
        if (state.ff2 == state.ff3)
        begin
            next_state.level = state.ff3;
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign level = state.level;

endmodule

// *** rtl/command_source_selector.sv ***
// How it works
// - start commands come from communication when the start source is 0 and from the terminals when it is 1.
// - the frequency command comes from communication when the speed source is 0 and from the terminals when 1.
// - speed source 2 marks the source external but keeps communication frequency and ignores terminal 2.
// - in network mode the option card commands when the network source is 0, the rs485 port when it is 1.
// - network source 9999 picks the rs485 port without an option card and the option card with one.
// - with automatic network source and a card fitted, rs485 writes, starts and frequencies are refused.
// - in panel mode the rs485 port commands for panel source 1 and the panel connector for panel source 2.
// - with network and panel sources both 1 the panel mode owns rs485 and network mode is refused.
// - a network mode that needs the option card is refused while no card is fitted.
// - network and panel source settings take writes at any time.
// - start and speed sources take writes only with user group 0 or with a card connected.
// - routing uses the operation mode, which is taken from the mode selection at power-on.
`timescale 1ns/1ps
module command_source_selector #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // option card presence pin
    input wire logic optionCardPin,
    // command routing
    output cmdsel_pkg::route_t route
);

    if (ADDR_W < 5 || ADDR_W > 8)
    begin : g_check
        $error("ADDR_W must be 5 to 8");
    end

    cmdsel_pkg::state_t state;
    cmdsel_pkg::state_t next_state;
    logic optPresent;
    logic [7:0] addr;

    assign addr = 8'(paddr);

    // clean option card presence
    option_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pinIn(optionCardPin),
        .level(optPresent)
    );

    // network source resolves to the rs485 port
    function automatic logic netOnRs485(input logic [15:0] netSrc, input logic opt);
        netOnRs485 = (netSrc == cmdsel_pkg::NET_RS485) || (netSrc == cmdsel_pkg::NET_AUTO && !opt);
    endfunction

    // network mode must be refused in the present configuration
    function automatic logic netRefused(input logic [15:0] netSrc, input logic [15:0] puSrc, input logic opt);
        logic rs;
        rs = netOnRs485(netSrc, opt);
        netRefused = (rs && puSrc == cmdsel_pkg::PU_RS485)
            || (!rs && !opt);
    endfunction

    // mode entered at power-on from the mode selection
    function automatic cmdsel_pkg::mode_t bootMode(input logic [15:0] modeSel);
        case (modeSel)
            16'h0001: bootMode = cmdsel_pkg::MODE_PU;
            16'h0003, 16'h0004: bootMode = cmdsel_pkg::MODE_COMB;
            default: bootMode = cmdsel_pkg::MODE_EXT;
        endcase
    endfunction

    // whether a requested mode is allowed by the stored mode selection
    function automatic logic switchOk(input cmdsel_pkg::mode_t cur, input logic [3:0] req,
        input logic [15:0] modeSel);
        case (modeSel)
            16'h0000, 16'h0006, 16'h0007:
                switchOk = (req == cmdsel_pkg::MODE_EXT || req == cmdsel_pkg::MODE_PU
                    || req == cmdsel_pkg::MODE_NET)
                    && !(cur == cmdsel_pkg::MODE_PU && req == cmdsel_pkg::MODE_NET)
                    && !(cur == cmdsel_pkg::MODE_NET && req == cmdsel_pkg::MODE_PU);
            16'h0001: switchOk = (req == cmdsel_pkg::MODE_PU);
            16'h0002: switchOk = (req == cmdsel_pkg::MODE_EXT || req == cmdsel_pkg::MODE_NET);
            16'h0003, 16'h0004: switchOk = (req == cmdsel_pkg::MODE_COMB);
            default: switchOk = 1'b0;
        endcase
    endfunction

    // routing derived from the settings, the mode and card presence
    function automatic cmdsel_pkg::route_t routeOf(input cmdsel_pkg::state_t s, input logic opt);
        logic netActive;
        logic puActive;
        logic rs;
        netActive = (s.opMode == cmdsel_pkg::MODE_NET);
        puActive = (s.opMode == cmdsel_pkg::MODE_PU);
        rs = netOnRs485(s.netSrc, opt);
        routeOf.startComm = netActive && s.startSrc == cmdsel_pkg::SRC_COMM;
        routeOf.startExt = netActive && s.startSrc == cmdsel_pkg::SRC_EXT;
        routeOf.freqComm = netActive && (s.speedSrc == cmdsel_pkg::SRC_COMM
            || s.speedSrc == cmdsel_pkg::SPEED_EXT_COMM);
        routeOf.freqExt = netActive && (s.speedSrc == cmdsel_pkg::SRC_EXT
            || s.speedSrc == cmdsel_pkg::SPEED_EXT_COMM);
        routeOf.term2Ignore = netActive && s.speedSrc == cmdsel_pkg::SPEED_EXT_COMM;
        routeOf.rs485Cmd = (puActive && s.puSrc == cmdsel_pkg::PU_RS485)
            || (netActive && rs);
        routeOf.optionCmd = netActive && !rs;
        routeOf.connectorCmd = puActive && s.puSrc == cmdsel_pkg::PU_CONNECTOR;
        routeOf.rs485Blocked = s.netSrc == cmdsel_pkg::NET_AUTO && opt;
        routeOf.netLocked = netRefused(s.netSrc, s.puSrc, opt);
    endfunction

    // register read data
    function automatic logic [31:0] readReg(input logic [7:0] a, input cmdsel_pkg::state_t s, input logic opt);
        readReg = 32'h0000_0000;
        case (a)
            cmdsel_pkg::OFS_START: readReg = {16'h0000, s.startSrc};
            cmdsel_pkg::OFS_SPEED: readReg = {16'h0000, s.speedSrc};
            cmdsel_pkg::OFS_NET: readReg = {16'h0000, s.netSrc};
            cmdsel_pkg::OFS_PU: readReg = {16'h0000, s.puSrc};
            cmdsel_pkg::OFS_USERGRP: readReg = {16'h0000, s.userGroup};
            cmdsel_pkg::OFS_MODESEL: readReg = {16'h0000, s.modeSel};
            cmdsel_pkg::OFS_MODEREQ: readReg = {28'h000_0000, s.opMode};
            cmdsel_pkg::OFS_STATUS:
            begin
                readReg[cmdsel_pkg::ST_MODE_LSB +: 4] = s.opMode;
                readReg[cmdsel_pkg::ST_ROUTE_LSB +: 10] = s.route;
                readReg[cmdsel_pkg::ST_REFUSED] = s.refused;
                readReg[cmdsel_pkg::ST_OPTION] = opt;
            end
            default: readReg = 32'h0000_0000;
        endcase
    endfunction

    // write check: unmapped, out of range, protected or refused
    function automatic logic writeErr(input logic [7:0] a, input logic [31:0] d, input cmdsel_pkg::state_t s,
        input logic opt);
        logic [15:0] v;
        v = d[15:0];
        case (a)
            cmdsel_pkg::OFS_START:
                writeErr = v > cmdsel_pkg::SRC_EXT
                    || !(s.userGroup == cmdsel_pkg::USERGRP_OPEN || opt);
            cmdsel_pkg::OFS_SPEED:
                writeErr = v > cmdsel_pkg::SPEED_EXT_COMM
                    || !(s.userGroup == cmdsel_pkg::USERGRP_OPEN || opt);
            cmdsel_pkg::OFS_NET:
                writeErr = !(v == cmdsel_pkg::NET_OPTION || v == cmdsel_pkg::NET_RS485
                    || v == cmdsel_pkg::NET_AUTO);
            cmdsel_pkg::OFS_PU:
                writeErr = !(v == cmdsel_pkg::PU_RS485 || v == cmdsel_pkg::PU_CONNECTOR);
            cmdsel_pkg::OFS_USERGRP: writeErr = 1'b0;
            cmdsel_pkg::OFS_MODESEL: writeErr = v > cmdsel_pkg::MODESEL_MAX || v == 16'h0005;
            cmdsel_pkg::OFS_MODEREQ:
                writeErr = !switchOk(s.opMode, d[3:0], s.modeSel)
                    || (d[3:0] == cmdsel_pkg::MODE_NET && netRefused(s.netSrc, s.puSrc, opt));
            default: writeErr = 1'b1;
        endcase
    endfunction

    // next state: apb slave with one wait state, boot mode, routing
    always_comb
    begin
        logic access;
        logic done;
        logic [15:0] v;
        access = psel && penable;
        done = access && state.pready;
        v = pwdata[15:0];
        next_state = state;
        next_state.pready = access && !state.pready;
        next_state.pslverr = 1'b0;
        next_state.prdata = 32'h0000_0000;
        if (access && !state.pready)
        begin
            if (pwrite)
            begin
                next_state.pslverr = writeErr(addr, pwdata, state, optPresent);
            end
            else
            begin
                next_state.prdata = readReg(addr, state, optPresent);
                next_state.pslverr = (addr > cmdsel_pkg::OFS_STATUS) || (addr[1:0] != 2'b00);
            end
        end
        if (!state.booted)
        begin
            next_state.booted = 1'b1;
            next_state.opMode = bootMode(state.modeSel);
        end
        else if (state.opMode == cmdsel_pkg::MODE_NET && netRefused(state.netSrc, state.puSrc, optPresent))
        begin
            next_state.opMode = cmdsel_pkg::MODE_EXT;
        end
        if (done && pwrite && addr == cmdsel_pkg::OFS_MODEREQ)
        begin
            next_state.refused = state.pslverr;
        end
        if (done && pwrite && !state.pslverr)
        begin
            case (addr)
                cmdsel_pkg::OFS_START: next_state.startSrc = v;
                cmdsel_pkg::OFS_SPEED: next_state.speedSrc = v;
                cmdsel_pkg::OFS_NET: next_state.netSrc = v;
                cmdsel_pkg::OFS_PU: next_state.puSrc = v;
                cmdsel_pkg::OFS_USERGRP: next_state.userGroup = v;
                cmdsel_pkg::OFS_MODESEL: next_state.modeSel = v;
                cmdsel_pkg::OFS_MODEREQ: next_state.opMode = cmdsel_pkg::mode_t'(pwdata[3:0]);
                default: next_state.modeSel = state.modeSel;
            endcase
        end
        next_state.route = routeOf(state, optPresent);
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= cmdsel_pkg::STATE_RST;
        end
        else
        begin
            state <= next_state;
        end
    end

    // outputs straight from the state register
    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign route = state.route;

    // start source 0 in network mode routes starts to communication
    property p_start_comm;
        @(posedge clk) disable iff (!arst_n)
        (state.opMode == cmdsel_pkg::MODE_NET && state.startSrc == 16'h0000)
            |=> (route.startComm && !route.startExt);
    endproperty
    a_start_comm: assert property (p_start_comm) else $error("start not from communication");

    // speed source 1 routes frequency to the terminals only
    property p_freq_ext;
        @(posedge clk) disable iff (!arst_n)
        (state.opMode == cmdsel_pkg::MODE_NET && state.speedSrc == 16'h0001)
            |=> (route.freqExt && !route.freqComm && !route.term2Ignore);
    endproperty
    a_freq_ext: assert property (p_freq_ext) else $error("frequency not from terminals");

    // speed source 2 keeps communication frequency and drops terminal 2
    property p_freq_mixed;
        @(posedge clk) disable iff (!arst_n)
        (state.opMode == cmdsel_pkg::MODE_NET && state.speedSrc == 16'h0002)
            |=> (route.freqExt && route.freqComm && route.term2Ignore);
    endproperty
    a_freq_mixed: assert property (p_freq_mixed) else $error("mixed frequency source wrong");

    // network source 0 hands network commands to the option card
    property p_net_option;
        @(posedge clk) disable iff (!arst_n)
        (state.opMode == cmdsel_pkg::MODE_NET && state.netSrc == 16'h0000)
            |=> (route.optionCmd && !route.rs485Cmd);
    endproperty
    a_net_option: assert property (p_net_option) else $error("option card not commanding");

    // automatic network source without a card uses rs485
    property p_net_auto;
        @(posedge clk) disable iff (!arst_n)
        (state.opMode == cmdsel_pkg::MODE_NET && state.netSrc == 16'h270F && !optPresent)
            |=> (route.rs485Cmd && !route.optionCmd);
    endproperty
    a_net_auto: assert property (p_net_auto) else $error("automatic source not rs485");

    // automatic network source with a card blocks rs485 commands
    property p_rs485_block;
        @(posedge clk) disable iff (!arst_n)
        (state.netSrc == 16'h270F && optPresent) |=> route.rs485Blocked;
    endproperty
    a_rs485_block: assert property (p_rs485_block) else $error("rs485 not blocked");

    // panel source 2 in panel mode gives the connector the commands
    property p_pu_connector;
        @(posedge clk) disable iff (!arst_n)
        (state.opMode == cmdsel_pkg::MODE_PU && state.puSrc == 16'h0002)
            |=> (route.connectorCmd && !route.rs485Cmd);
    endproperty
    a_pu_connector: assert property (p_pu_connector) else $error("connector not commanding");

    // a refused network request keeps network mode out and sets the refused flag
    property p_net_refused;
        @(posedge clk) disable iff (!arst_n)
        (psel && penable && pready && pwrite && addr == 8'h18 && pwdata[3:0] == 4'b0100
            && netRefused(state.netSrc, state.puSrc, optPresent) && state.booted)
            |=> (state.opMode != cmdsel_pkg::MODE_NET && state.refused);
    endproperty
    a_net_refused: assert property (p_net_refused) else $error("network mode entered");

    // network source writes land whatever the mode
    property p_net_write;
        @(posedge clk) disable iff (!arst_n)
        (psel && penable && pready && !pslverr && pwrite && addr == 8'h08)
            |=> (state.netSrc == $past(pwdata[15:0]));
    endproperty
    a_net_write: assert property (p_net_write) else $error("network source write lost");

    // protected start source stays put
    property p_start_protect;
        @(posedge clk) disable iff (!arst_n)
        (psel && penable && !pready && pwrite && addr == 8'h00 && state.userGroup != 16'h0000 && !optPresent)
            |=> (pslverr ##1 $stable(state.startSrc));
    endproperty
    a_start_protect: assert property (p_start_protect) else $error("protected write taken");

endmodule

// *** testbench/option_card_model.sv ***
`timescale 1ns/1ps
module option_card_model (
    // clock
    input wire logic clk,
    // bench command to plug or pull the card
    input wire logic fitted,
    // presence level seen by the drive
    output logic optionCardPin
);
    // the card is plugged or pulled only just after a clock edge
    always @(posedge clk)
        optionCardPin <= fitted;
endmodule

// *** testbench/command_source_selector_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module command_source_selector_tb;
    logic clk;
    logic arst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fitted;
    logic optionCardPin;
    cmdsel_pkg::route_t route;
    int fails = 0;
    int cmp_count = 0;

    // device under test and the option card beside it
    command_source_selector command_source_selector_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .optionCardPin(optionCardPin), .route(route));
    option_card_model option_card_model_inst (.clk(clk), .fitted(fitted), .optionCardPin(optionCardPin));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // one apb transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung wait
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // access with an expected error flag
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic expErr);
        logic [31:0] rd;
        logic err;
        xfer(w, a, d, rd, err);
        `CHK(err, expErr)
    endtask

    // read with an expected value
    task automatic rdv(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        xfer(1'b0, a, 32'h0000_0000, rd, err);
        `CHK(err, 1'b0)
        `CHK(rd, exp)
    endtask

    // let the routing follow a stored write
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    // plug or pull the card and wait for the synchroniser
    task automatic card(input logic v);
        fitted <= v;
        repeat (10) @(posedge clk);
    endtask

    // verdict and end of run
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end

    // main sequence
    initial
    begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        fitted = 1'b0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        // reset values and power-on mode
        rdv(cmdsel_pkg::OFS_START, 32'h0000_0000);
        rdv(cmdsel_pkg::OFS_SPEED, 32'h0000_0000);
        rdv(cmdsel_pkg::OFS_NET, 32'h0000_270F);
        rdv(cmdsel_pkg::OFS_PU, 32'h0000_0002);
        rdv(cmdsel_pkg::OFS_MODEREQ, 32'(cmdsel_pkg::MODE_EXT));
        acc(1'b0, 8'h20, 32'h0000_0000, 1'b1);
        acc(1'b1, cmdsel_pkg::OFS_STATUS, 32'h0000_0000, 1'b1);
        // both sources on rs485 keep network mode out
        acc(1'b1, cmdsel_pkg::OFS_NET, 32'h0000_0001, 1'b0);
        acc(1'b1, cmdsel_pkg::OFS_PU, 32'h0000_0001, 1'b0);
        settle();
        `CHK(route.netLocked, 1'b1)
        acc(1'b1, cmdsel_pkg::OFS_MODEREQ, 32'h0000_0004, 1'b1);
        // option card source without a card
        acc(1'b1, cmdsel_pkg::OFS_NET, 32'h0000_0000, 1'b0);
        acc(1'b1, cmdsel_pkg::OFS_PU, 32'h0000_0002, 1'b0);
        settle();
        `CHK(route.netLocked, 1'b1)
        acc(1'b1, cmdsel_pkg::OFS_MODEREQ, 32'h0000_0004, 1'b1);
        // automatic source without a card picks rs485
        acc(1'b1, cmdsel_pkg::OFS_NET, 32'h0000_270F, 1'b0);
        settle();
        acc(1'b1, cmdsel_pkg::OFS_MODEREQ, 32'h0000_0004, 1'b0);
        rdv(cmdsel_pkg::OFS_MODEREQ, 32'(cmdsel_pkg::MODE_NET));
        settle();
        `CHK({route.rs485Cmd, route.optionCmd}, 2'b10)
        // start and frequency sources in network mode
        acc(1'b1, cmdsel_pkg::OFS_START, 32'h0000_0001, 1'b0);
        settle();
        `CHK({route.startComm, route.startExt}, 2'b01)
        acc(1'b1, cmdsel_pkg::OFS_START, 32'h0000_0000, 1'b0);
        settle();
        `CHK({route.startComm, route.startExt}, 2'b10)
        acc(1'b1, cmdsel_pkg::OFS_SPEED, 32'h0000_0001, 1'b0);
        settle();
        `CHK({route.freqComm, route.freqExt, route.term2Ignore}, 3'b010)
        acc(1'b1, cmdsel_pkg::OFS_SPEED, 32'h0000_0002, 1'b0);
        settle();
        `CHK({route.freqComm, route.term2Ignore}, 2'b11)
        acc(1'b1, cmdsel_pkg::OFS_SPEED, 32'h0000_0000, 1'b0);
        settle();
        `CHK({route.freqComm, route.freqExt, route.term2Ignore}, 3'b100)
        acc(1'b1, cmdsel_pkg::OFS_START, 32'h0000_0002, 1'b1);
        acc(1'b1, cmdsel_pkg::OFS_SPEED, 32'h0000_0003, 1'b1);
        // a fitted card takes over and blocks rs485 commands
        card(1'b1);
        `CHK({route.rs485Cmd, route.optionCmd, route.rs485Blocked}, 3'b011)
        acc(1'b1, cmdsel_pkg::OFS_NET, 32'h0000_0000, 1'b0);
        settle();
        `CHK({route.rs485Cmd, route.optionCmd}, 2'b01)
        acc(1'b1, cmdsel_pkg::OFS_NET, 32'h0000_0001, 1'b0);
        settle();
        `CHK({route.rs485Cmd, route.optionCmd, route.rs485Blocked}, 3'b100)
        // pulling the card drops network mode
        acc(1'b1, cmdsel_pkg::OFS_NET, 32'h0000_0000, 1'b0);
        settle();
        card(1'b0);
        rdv(cmdsel_pkg::OFS_MODEREQ, 32'(cmdsel_pkg::MODE_EXT));
        // start and speed sources locked by the user group unless a card is in
        acc(1'b1, cmdsel_pkg::OFS_USERGRP, 32'h0000_0001, 1'b0);
        acc(1'b1, cmdsel_pkg::OFS_START, 32'h0000_0001, 1'b1);
        rdv(cmdsel_pkg::OFS_START, 32'h0000_0000);
        acc(1'b1, cmdsel_pkg::OFS_NET, 32'h0000_270F, 1'b0);
        acc(1'b1, cmdsel_pkg::OFS_PU, 32'h0000_0001, 1'b0);
        card(1'b1);
        acc(1'b1, cmdsel_pkg::OFS_SPEED, 32'h0000_0001, 1'b0);
        rdv(cmdsel_pkg::OFS_SPEED, 32'h0000_0001);
        card(1'b0);
        // panel mode source selection
        acc(1'b1, cmdsel_pkg::OFS_MODEREQ, 32'h0000_0002, 1'b0);
        settle();
        `CHK({route.rs485Cmd, route.connectorCmd}, 2'b10)
        acc(1'b1, cmdsel_pkg::OFS_PU, 32'h0000_0002, 1'b0);
        settle();
        `CHK({route.rs485Cmd, route.connectorCmd}, 2'b01)
        acc(1'b1, cmdsel_pkg::OFS_PU, 32'h0000_0003, 1'b1);
        acc(1'b1, cmdsel_pkg::OFS_MODEREQ, 32'h0000_0004, 1'b1);
        // status: panel mode, connector commanding, last request refused, no card
        rdv(cmdsel_pkg::OFS_STATUS, 32'h0000_4042);
        // mode selection limits later requests but is stored only
        acc(1'b1, cmdsel_pkg::OFS_MODESEL, 32'h0000_0005, 1'b1);
        acc(1'b1, cmdsel_pkg::OFS_MODESEL, 32'h0000_0002, 1'b0);
        acc(1'b1, cmdsel_pkg::OFS_MODEREQ, 32'h0000_0002, 1'b1);
        acc(1'b1, cmdsel_pkg::OFS_MODEREQ, 32'h0000_0001, 1'b0);
        rdv(cmdsel_pkg::OFS_MODEREQ, 32'(cmdsel_pkg::MODE_EXT));
        // reset in mid-run brings back the reset settings
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdv(cmdsel_pkg::OFS_MODESEL, 32'h0000_0000);
        rdv(cmdsel_pkg::OFS_SPEED, 32'h0000_0000);
        rdv(cmdsel_pkg::OFS_USERGRP, 32'h0000_0000);
        rdv(cmdsel_pkg::OFS_STATUS, 32'h0000_0001);
        final_report();
    end
endmodule
